// ---- src/reset_seq_defines.svh ----
// Summary of operation
// RL1: Reset pin low one machine cycle minimum
// RL2: Count 5359 oscillator clocks before running
// RL3: Start execution at page 0, address 0
// RL4: Clock mode control resets to 1100
// RL5: First interrupt control and enable cleared
// RL6: Edge interrupt control cleared to zero
// RL7: Sixth timer control cleared to 0000
// RL8: All three key wakeup controls cleared
// RL9: All three pull-up controls cleared
// RL10: Converter control cleared, mode and channel zero
// RL11: External interrupt request flag cleared
// RL12: Software initialises working registers after release
// RL13: Software initialises all undefined state
// RL14: Power-down flag cleared by reset only; the code also clears it on power_down_clr
// RL15: Re-entered reset restarts the wait count
`ifndef RESET_SEQ_DEFINES_SVH
`define RESET_SEQ_DEFINES_SVH

// ----------------------------------------
// Timing counts
// ----------------------------------------
// Oscillator clocks per machine cycle
`define MACHINE_CYCLE_CLKS 4
// Stabilisation wait in oscillator clocks
`define STAB_CYCLES 5359
// Width of the wait counter
`define STAB_CNT_W 13
// Width of the machine cycle counter
`define MC_CNT_W 3

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define PC_PAGE_W 6
`define PC_ADDR_W 7
`define PC_PAGE_RST 6'h00
`define PC_ADDR_RST 7'h00
`define CLOCK_MODE_RST 4'hC
`define CTRL4_ZERO 4'h0
`define WAKE_BANKS 3

`endif

// ---- src/reset_seq_pkg.sv ----
package reset_seq_pkg;

    // Sequencer phase
    typedef enum {ST_HOLD, ST_STAB, ST_RUN} seq_state_t;

    // Target of a software write
    typedef enum logic [2:0] {
        SEL_CLOCK_MODE,
        SEL_IRQ_FIRST,
        SEL_EDGE_IRQ,
        SEL_TIMER_SIXTH,
        SEL_KEY_WAKE,
        SEL_PULLUP,
        SEL_CONVERTER
    } reg_sel_t;

endpackage : reset_seq_pkg

// ---- src/reset_pin_qualifier.sv ----
`timescale 1ns/1ps
`include "reset_seq_defines.svh"

module reset_pin_qualifier (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // External reset pin, active low
    input wire logic reset_pin_n,
    // Qualified reset level
    output logic hold
);
    // ----------------------------------------
    // Low-time measurement
    // ----------------------------------------
    logic [`MC_CNT_W-1:0] low_cnt_reg; // Clocks seen low so far
    logic [`MC_CNT_W-1:0] low_cnt_next;
    logic hold_reg; // Reset being applied
    logic hold_next;

    // Next-state for the low-time counter
    always_comb begin
        low_cnt_next = low_cnt_reg;
        hold_next = hold_reg;
        if (reset_pin_n) begin
            // Pin released: reset ends, measurement restarts
            low_cnt_next = '0;
            hold_next = 1'b0;
        // RL1 minimum low time
        end else if (low_cnt_reg == `MC_CNT_W'(`MACHINE_CYCLE_CLKS - 1)) begin
            // Short glitches never reach here, so they are ignored
            hold_next = 1'b1;
        end else begin
            low_cnt_next = low_cnt_reg + `MC_CNT_W'(1);
        end
    end

    // Registers; power-up counts as a reset being applied
    always_ff @(posedge clk) begin
        if (!rstn) begin
            low_cnt_reg <= '0;
            hold_reg <= 1'b1;
        end else if (ce) begin
            low_cnt_reg <= low_cnt_next;
            hold_reg <= hold_next;
        end
    end

    assign hold = hold_reg;

endmodule : reset_pin_qualifier

// ---- src/reset_release_sequencer.sv ----
`timescale 1ns/1ps
`include "reset_seq_defines.svh"

module reset_release_sequencer
    import reset_seq_pkg::*;
#(
    parameter int STAB_CYCLES = `STAB_CYCLES
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // External reset pin
    input wire logic reset_pin_n,
    // Software register write port
    input wire logic wr_en,
    input wire reg_sel_t wr_sel,
    input wire logic [1:0] wr_bank,
    input wire logic [3:0] wr_data,
    // Flag events and clears
    input wire logic ext_irq_event,
    input wire logic ext_irq_clr,
    input wire logic gie_set,
    input wire logic gie_clr,
    input wire logic standby_wake,
    input wire logic power_down_clr,
    // Sequencer status
    output logic in_reset,
    output logic stab_busy,
    output logic cpu_run,
    output logic pc_load,
    output logic [`PC_PAGE_W-1:0] pc_page,
    output logic [`PC_ADDR_W-1:0] pc_addr,
    // Control registers
    output logic [3:0] clock_mode_control,
    output logic [3:0] interrupt_control_first,
    output logic [3:0] edge_interrupt_control,
    output logic [3:0] timer_control_sixth,
    output logic [3:0] key_wakeup_control [`WAKE_BANKS],
    output logic [3:0] pullup_control [`WAKE_BANKS],
    output logic [3:0] converter_control,
    // Flags
    output logic external_irq_request_flag,
    output logic global_interrupt_enable,
    output logic power_down_flag
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Write-or-hold decode shared by every control register
    function automatic logic [3:0] upd4(input logic [3:0] cur, input logic hit, input logic [3:0] d);
        upd4 = hit ? d : cur;
    endfunction : upd4
    // Set beats clear so a coincident event is never lost
    function automatic logic flag_upd(input logic cur, input logic set, input logic clr);
        flag_upd = set | (cur & ~clr);
    endfunction : flag_upd

    // ----------------------------------------
    // Reset pin qualification
    // ----------------------------------------
    logic hold; // Qualified reset level
    reset_pin_qualifier u_qual (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .reset_pin_n(reset_pin_n),
        .hold(hold)
    );

    // ----------------------------------------
    // Release sequencer
    // ----------------------------------------
    seq_state_t state_reg, state_next; // Current phase
    logic [`STAB_CNT_W-1:0] cnt_reg, cnt_next; // Wait counter
    logic load_reg, load_next; // Start-of-execution pulse
    logic [`PC_PAGE_W-1:0] page_reg, page_next; // Start page
    logic [`PC_ADDR_W-1:0] addr_reg, addr_next; // Start address
    // Registered copy of the phase (run, wait, hold) so status pins come from flops
    logic [2:0] phase_reg, phase_next;
    logic force_rst; // Reset values imposed
    logic sw_ok; // Software writes accepted
    assign force_rst = (state_reg != ST_RUN);
    assign sw_ok = (state_reg == ST_RUN) && wr_en;

    // Phase and counter next values
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        load_next = 1'b0;
        page_next = page_reg;
        addr_next = addr_reg;
        case (state_reg)
            ST_HOLD: begin
                // Counter kept at zero while reset is held
                cnt_next = '0;
                if (!hold) begin
                    state_next = ST_STAB;
                end
            end
            ST_STAB: begin
                if (hold) begin
                    // RL15 restart the wait
                    state_next = ST_HOLD;
                    cnt_next = '0;
                // RL2 full wait elapsed
                end else if (cnt_reg == `STAB_CNT_W'(STAB_CYCLES - 1)) begin
                    state_next = ST_RUN;
                    // RL3 fetch from origin
                    load_next = 1'b1;
                    page_next = `PC_PAGE_RST;
                    addr_next = `PC_ADDR_RST;
                end else begin
                    cnt_next = cnt_reg + `STAB_CNT_W'(1);
                end
            end
            ST_RUN: begin
                // Any qualified reset stops execution at once
                if (hold) begin
                    state_next = ST_HOLD;
                    cnt_next = '0;
                end
            end
            default: begin
                state_next = ST_HOLD;
                cnt_next = '0;
            end
        endcase
        // Status flops follow the phase the state register is about to take
        phase_next = {state_next == ST_RUN, state_next == ST_STAB, state_next == ST_HOLD};
    end
    // Phase registers
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_reg <= ST_HOLD;
            phase_reg <= 3'h1;
            cnt_reg <= '0;
            load_reg <= 1'b0;
            page_reg <= `PC_PAGE_RST;
            addr_reg <= `PC_ADDR_RST;
        end else if (ce) begin
            state_reg <= state_next;
            phase_reg <= phase_next;
            cnt_reg <= cnt_next;
            load_reg <= load_next;
            page_reg <= page_next;
            addr_reg <= addr_next;
        end
    end

    // ----------------------------------------
    // Single control registers and flags
    // ----------------------------------------
    logic [3:0] mode_reg, mode_next;
    logic [3:0] irq1_reg, irq1_next;
    logic [3:0] edge_reg, edge_next;
    logic [3:0] tim6_reg, tim6_next;
    logic [3:0] conv_reg, conv_next;
    logic exf_reg, exf_next;
    logic gie_reg, gie_next;
    logic pdf_reg, pdf_next;
    // Next values: forced while held or waiting, else software
    always_comb begin
        if (force_rst) begin
            // RL4 clock mode reset value
            mode_next = `CLOCK_MODE_RST;
            // RL5 interrupts disabled
            irq1_next = `CTRL4_ZERO;
            gie_next = 1'b0;
            // RL6 edge control cleared
            edge_next = `CTRL4_ZERO;
            // RL7 timer control cleared
            tim6_next = `CTRL4_ZERO;
            // RL10 converter mode and channel zero
            conv_next = `CTRL4_ZERO;
            // RL11 request flag cleared
            exf_next = 1'b0;
            // RL14 cold start marker
            pdf_next = 1'b0;
        end else begin
            mode_next = upd4(mode_reg, sw_ok && wr_sel == SEL_CLOCK_MODE, wr_data);
            irq1_next = upd4(irq1_reg, sw_ok && wr_sel == SEL_IRQ_FIRST, wr_data);
            edge_next = upd4(edge_reg, sw_ok && wr_sel == SEL_EDGE_IRQ, wr_data);
            tim6_next = upd4(tim6_reg, sw_ok && wr_sel == SEL_TIMER_SIXTH, wr_data);
            conv_next = upd4(conv_reg, sw_ok && wr_sel == SEL_CONVERTER, wr_data);
            exf_next = flag_upd(exf_reg, ext_irq_event, ext_irq_clr);
            gie_next = flag_upd(gie_reg, gie_set, gie_clr);
            // Wakeup from standby marks a warm start
            pdf_next = flag_upd(pdf_reg, standby_wake, power_down_clr);
        end
    end
    // Registers for the group; values undefined before first reset
    always_ff @(posedge clk) begin
        if (!rstn) begin
            mode_reg <= `CLOCK_MODE_RST;
            irq1_reg <= `CTRL4_ZERO;
            edge_reg <= `CTRL4_ZERO;
            tim6_reg <= `CTRL4_ZERO;
            conv_reg <= `CTRL4_ZERO;
            exf_reg <= 1'b0;
            gie_reg <= 1'b0;
            pdf_reg <= 1'b0;
        end else if (ce) begin
            mode_reg <= mode_next;
            irq1_reg <= irq1_next;
            edge_reg <= edge_next;
            tim6_reg <= tim6_next;
            conv_reg <= conv_next;
            exf_reg <= exf_next;
            gie_reg <= gie_next;
            pdf_reg <= pdf_next;
        end
    end

    // ----------------------------------------
    // Banked wakeup and pull-up registers
    // ----------------------------------------
    logic [3:0] key_reg [`WAKE_BANKS];
    logic [3:0] pull_reg [`WAKE_BANKS];

    for (genvar b = 0; b < `WAKE_BANKS; b++) begin : g_bank
        logic [3:0] key_next;
        logic [3:0] pull_next;
        logic bank_hit; // Write addresses this bank
        assign bank_hit = sw_ok && (wr_bank == 2'(b));
        // Next values for one bank
        always_comb begin
            // RL8 wakeup sources off
            key_next = force_rst ? `CTRL4_ZERO : upd4(key_reg[b], bank_hit && wr_sel == SEL_KEY_WAKE, wr_data);
            // RL9 pull-ups off
            pull_next = force_rst ? `CTRL4_ZERO : upd4(pull_reg[b], bank_hit && wr_sel == SEL_PULLUP, wr_data);
        end
        // Bank registers
        always_ff @(posedge clk) begin
            if (!rstn) begin
                key_reg[b] <= `CTRL4_ZERO;
                pull_reg[b] <= `CTRL4_ZERO;
            end else if (ce) begin
                key_reg[b] <= key_next;
                pull_reg[b] <= pull_next;
            end
        end
        assign key_wakeup_control[b] = key_reg[b];
        assign pullup_control[b] = pull_reg[b];
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Working registers and other state stay with software
    assign in_reset = phase_reg[0];
    assign stab_busy = phase_reg[1];
    assign cpu_run = phase_reg[2];
    assign pc_load = load_reg;
    assign pc_page = page_reg;
    assign pc_addr = addr_reg;
    assign clock_mode_control = mode_reg;
    assign interrupt_control_first = irq1_reg;
    assign edge_interrupt_control = edge_reg;
    assign timer_control_sixth = tim6_reg;
    assign converter_control = conv_reg;
    assign external_irq_request_flag = exf_reg;
    assign global_interrupt_enable = gie_reg;
    assign power_down_flag = pdf_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn || !ce);
    sequence wait_done_s;
        state_reg == ST_STAB && !hold && cnt_reg == `STAB_CNT_W'(STAB_CYCLES - 1);
    endsequence
    sequence start_s;
        state_reg == ST_RUN && pc_load && pc_page == '0 && pc_addr == '0;
    endsequence
    wait_to_run_a: assert property (wait_done_s |=> start_s) else $error("wait end did not start"); // RL2
    run_entry_a: assert property ($rose(cpu_run) |-> $past(cnt_reg) == `STAB_CNT_W'(STAB_CYCLES - 1))
        else $error("run entered early"); // RL2
    restart_wait_a: assert property (stab_busy && hold |=> in_reset && cnt_reg == '0)
        else $error("wait not restarted"); // RL15
    clock_mode_a: assert property (in_reset |=> clock_mode_control == `CLOCK_MODE_RST)
        else $error("clock mode not reset"); // RL4
    irq_off_a: assert property (in_reset |=> interrupt_control_first == '0 && !global_interrupt_enable)
        else $error("interrupts not disabled"); // RL5
    edge_ctrl_a: assert property (in_reset ##1 in_reset |-> edge_interrupt_control == '0)
        else $error("edge control not cleared"); // RL6
    timer_ctrl_a: assert property (stab_busy |-> timer_control_sixth == '0)
        else $error("timer control not cleared"); // RL7
    wake_pull_a: assert property (stab_busy |-> key_wakeup_control[2] == '0 && pullup_control[0] == '0)
        else $error("wakeup or pull-up not cleared"); // RL8
    conv_ctrl_a: assert property ($rose(cpu_run) |-> converter_control == '0)
        else $error("converter not cleared"); // RL10
    irq_flag_a: assert property (stab_busy |-> !external_irq_request_flag)
        else $error("request flag not cleared"); // RL11
    cold_start_a: assert property ($rose(cpu_run) |-> !power_down_flag)
        else $error("power-down flag set at start"); // RL14
endmodule : reset_release_sequencer

// ---- verification/reset_circuit_model.sv ----
`timescale 1ns/1ps

module reset_circuit_model (
    // Clock
    input wire logic clk,
    // Pulse request from the bench
    input wire logic pulse_req,
    input wire logic [7:0] pulse_len,
    // Reset pin, pulled up when released
    output logic reset_pin_n
);
    // Low cycles still to run
    logic [7:0] low_reg = 8'h00;

    // ----------------------------------------
    // Pulse timing
    // ----------------------------------------
    // Reload on request, else count the pulse down
    always @(posedge clk) begin
        if (pulse_req) begin
            low_reg <= pulse_len;
        end else if (low_reg != 8'h00) begin
            low_reg <= low_reg - 8'h01;
        end
    end

    // low pulse width
    // Pin moves mid-cycle so no sampling edge races it; idle count leaves it pulled high
    always @(negedge clk) begin
        reset_pin_n <= (low_reg == 8'h00);
    end
endmodule : reset_circuit_model

// ---- verification/tb.sv ----
`timescale 1ns/1ps
`include "reset_seq_defines.svh"

module tb
    import reset_seq_pkg::*;
;
    // Short wait keeps the run brief
    localparam int STAB = 16;
    logic clk = 1'b0;
    logic rstn, ce, wr_en, pulse_req, run_exp;
    logic ext_irq_event, ext_irq_clr, gie_set, gie_clr, standby_wake, power_down_clr;
    reg_sel_t wr_sel;
    logic [1:0] wr_bank;
    logic [3:0] wr_data;
    logic [7:0] pulse_len;
    logic reset_pin_n, in_reset, stab_busy, cpu_run, pc_load;
    logic [`PC_PAGE_W-1:0] pc_page;
    logic [`PC_ADDR_W-1:0] pc_addr;
    logic [3:0] clock_mode_control, interrupt_control_first, edge_interrupt_control;
    logic [3:0] timer_control_sixth, converter_control;
    logic [3:0] key_wakeup_control [`WAKE_BANKS];
    logic [3:0] pullup_control [`WAKE_BANKS];
    logic external_irq_request_flag, global_interrupt_enable, power_down_flag;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    // Generator state, seed 57
    logic [31:0] rng = 32'h00000039;
    // Expected values, indexed by write target
    logic [3:0] exp_main [7];
    logic [3:0] exp_key [`WAKE_BANKS];
    logic [3:0] exp_pu [`WAKE_BANKS];
    // Expected irq request, enable, power-down
    logic [2:0] exp_flag;

    always #2.5 clk = ~clk;

    reset_circuit_model reset_circuit_model_i (.clk, .pulse_req, .pulse_len, .reset_pin_n);

    reset_release_sequencer #(.STAB_CYCLES(STAB)) reset_release_sequencer_i (
        .clk, .rstn, .ce, .reset_pin_n, .wr_en, .wr_sel, .wr_bank, .wr_data,
        .ext_irq_event, .ext_irq_clr, .gie_set, .gie_clr, .standby_wake, .power_down_clr,
        .in_reset, .stab_busy, .cpu_run, .pc_load, .pc_page, .pc_addr,
        .clock_mode_control, .interrupt_control_first, .edge_interrupt_control,
        .timer_control_sixth, .key_wakeup_control, .pullup_control, .converter_control,
        .external_irq_request_flag, .global_interrupt_enable, .power_down_flag
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xorshift

    // Reset value of a write target
    function automatic logic [3:0] rst_val(input int sel);
        return (sel == int'(SEL_CLOCK_MODE)) ? `CLOCK_MODE_RST : `CTRL4_ZERO;
    endfunction : rst_val

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test;
        if (miscompares == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    // Expectations back to reset values
    task automatic clear_exp;
        for (int i = 0; i < 7; i++) exp_main[i] = rst_val(i);
        for (int b = 0; b < `WAKE_BANKS; b++) begin
            exp_key[b] = 4'h0;
            exp_pu[b] = 4'h0;
        end
        exp_flag = 3'h0;
    endtask : clear_exp

    task automatic check_all;
        check(clock_mode_control, exp_main[0]);
        check(interrupt_control_first, exp_main[1]);
        check(edge_interrupt_control, exp_main[2]);
        check(timer_control_sixth, exp_main[3]);
        check(converter_control, exp_main[6]);
        for (int b = 0; b < `WAKE_BANKS; b++) begin
            check(key_wakeup_control[b], exp_key[b]);
            check(pullup_control[b], exp_pu[b]);
        end
        check({external_irq_request_flag, global_interrupt_enable, power_down_flag}, exp_flag);
    endtask : check_all

    // One write strobe; only taken while running
    task automatic write_reg(input reg_sel_t sel, input logic [1:0] bank, input logic [3:0] data);
        wr_en = 1'b1;
        wr_sel = sel;
        wr_bank = bank;
        wr_data = data;
        if (run_exp) begin
            if (sel == SEL_KEY_WAKE) begin
                if (bank != 2'h3) exp_key[bank] = data;
            end else if (sel == SEL_PULLUP) begin
                if (bank != 2'h3) exp_pu[bank] = data;
            end else begin
                exp_main[int'(sel)] = data;
            end
        end
        tick(1);
        wr_en = 1'b0;
        // Idle cycle so a following strobe is not raised in the same step
        tick(1);
    endtask : write_reg

    // Event and clear pulses; a set wins over a clear
    task automatic flag_ops(input logic [5:0] v);
        {ext_irq_event, ext_irq_clr, gie_set, gie_clr, standby_wake, power_down_clr} = v;
        if (run_exp) begin
            exp_flag[2] = v[5] | (exp_flag[2] & ~v[4]);
            exp_flag[1] = v[3] | (exp_flag[1] & ~v[2]);
            exp_flag[0] = v[1] | (exp_flag[0] & ~v[0]);
        end
        tick(1);
        {ext_irq_event, ext_irq_clr, gie_set, gie_clr, standby_wake, power_down_clr} = 6'h00;
        tick(1);
    endtask : flag_ops

    task automatic pin_pulse(input logic [7:0] len);
        pulse_req = 1'b1;
        pulse_len = len;
        tick(1);
        pulse_req = 1'b0;
        run_exp = 1'b0;
        clear_exp();
    endtask : pin_pulse

    task automatic wait_hold;
        for (int t = 0; t < 20 && in_reset !== 1'b1; t++) tick(1);
        check(in_reset, 16'h0001);
        tick(1);
        check_all();
    endtask : wait_hold

    // Counts wait cycles up to the start of execution
    task automatic wait_run;
        int n;
        n = 0;
        for (int t = 0; t < 200 && cpu_run !== 1'b1; t++) begin
            if (stab_busy === 1'b1) n++;
            tick(1);
        end
        check(n, STAB);
        check({pc_load, pc_page, pc_addr}, 16'h2000);
        tick(1);
        check(pc_load, 16'h0000);
        run_exp = 1'b1;
    endtask : wait_run

    // Hang guard, far above the few hundred cycles needed
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            finish_test();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rstn = 1'b0;
        ce = 1'b1;
        {wr_en, pulse_req, run_exp, wr_bank, wr_data, pulse_len} = '0;
        {ext_irq_event, ext_irq_clr, gie_set, gie_clr, standby_wake, power_down_clr} = 6'h00;
        wr_sel = SEL_CLOCK_MODE;
        clear_exp();
        tick(16);
        check(in_reset, 16'h0001);
        check({pc_page, pc_addr}, 16'h0000);
        check_all();
        rstn = 1'b1;
        wait_run();
        check_all();
        // Random writes and flag traffic
        // software sets initial values
        for (int i = 0; i < 48; i++) begin
            rng = xorshift(rng);
            if (rng[0]) begin
                write_reg(reg_sel_t'(int'(rng[10:8]) % 7), rng[13:12], rng[19:16]);
            end else begin
                flag_ops(rng[25:20]);
            end
            check_all();
        end
        // Set and clear together, then every register non-zero
        flag_ops(6'h3F);
        for (int s = 0; s < 7; s++) begin
            for (int b = 0; b < 4; b++) write_reg(reg_sel_t'(s), b[1:0], 4'hF);
        end
        check_all();
        // Frozen clock enable: a write must not land
        ce = 1'b0;
        run_exp = 1'b0;
        write_reg(SEL_CLOCK_MODE, 2'h0, 4'h3);
        run_exp = 1'b1;
        ce = 1'b1;
        check_all();
        // Pulse too short to count as reset
        pin_pulse(8'h03);
        run_exp = 1'b1;
        rng = xorshift(rng);
        exp_flag = 3'h7;
        for (int b = 0; b < `WAKE_BANKS; b++) begin
            exp_key[b] = 4'hF;
            exp_pu[b] = 4'hF;
        end
        for (int s = 0; s < 7; s++) exp_main[s] = 4'hF;
        tick(8);
        check(cpu_run, 16'h0001);
        check_all();
        // Pin reset, then re-entry in mid-wait with a refused write
        pin_pulse(8'h04);
        wait_hold();
        for (int t = 0; t < 20 && stab_busy !== 1'b1; t++) tick(1);
        tick(3);
        write_reg(SEL_CONVERTER, 2'h0, 4'h9);
        pin_pulse(8'h06);
        wait_hold();
        wait_run();
        check_all();
        finish_test();
    end
endmodule : tb
